// ==== sim/cell_switch_config_regs_test.sv ====
// self-checking bench of the switch config register block
`timescale 1ns/1ps
module cell_switch_config_regs_test;
	import csc_pkg::*;
	logic        ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        bus_request, bus_grant, frame_tick, no_grant_alarm;
	logic [4:0]  cell_dest_id;
	logic        cell_multicast, cell_for_us, cell_accept, cell_queue_class;
	logic [3:0]  cell_queue_port, congestion_mark, outlet_port;
	logic        bus_monitor_mode, discard_active, free_list_reload;
	logic [13:0] best_effort_fill;
	logic [9:0]  free_list_head_pointer;
	logic        wide_interface_select, single_phy_select;
	logic [11:0] queue_len [CSC_NUM_CLASS];
	logic [11:0] queue_max [CSC_NUM_CLASS];
	logic [5:0]  inlet_cell_bytes, outlet_cell_bytes, e;
	logic [15:0] port_enable, poll_enable;
	logic        outlet_multicast, outlet_discard, er;
	logic [7:0]  rd;
	int          mismatches, checks_done, cyc;
	csc_config_regs u_dut
	(
		.ref_clk                (ref_clk),
		.rst_b                  (rst_b),
		.psel                   (psel),
		.penable                (penable),
		.pwrite                 (pwrite),
		.paddr                  (paddr),
		.pwdata                 (pwdata),
		.pready                 (pready),
		.prdata                 (prdata),
		.pslverr                (pslverr),
		.irq                    (irq),
		.bus_request            (bus_request),
		.bus_grant              (bus_grant),
		.frame_tick             (frame_tick),
		.no_grant_alarm         (no_grant_alarm),
		.cell_dest_id           (cell_dest_id),
		.cell_multicast         (cell_multicast),
		.cell_for_us            (cell_for_us),
		.cell_accept            (cell_accept),
		.cell_queue_port        (cell_queue_port),
		.cell_queue_class       (cell_queue_class),
		.bus_monitor_mode       (bus_monitor_mode),
		.best_effort_fill       (best_effort_fill),
		.discard_active         (discard_active),
		.free_list_reload       (free_list_reload),
		.free_list_head_pointer (free_list_head_pointer),
		.wide_interface_select  (wide_interface_select),
		.single_phy_select      (single_phy_select),
		.queue_len              (queue_len),
		.queue_max              (queue_max),
		.congestion_mark        (congestion_mark),
		.inlet_cell_bytes       (inlet_cell_bytes),
		.outlet_cell_bytes      (outlet_cell_bytes),
		.port_enable            (port_enable),
		.poll_enable            (poll_enable),
		.outlet_port            (outlet_port),
		.outlet_multicast       (outlet_multicast),
		.outlet_discard         (outlet_discard)
	);
	always #20 ref_clk = ~ref_clk;
	task chk(input logic [15:0] g, input logic [15:0] x);
		checks_done++;
		if (g !== x)
		begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, g, x);
		end
	endtask : chk
	task apb(input logic w, input logic [9:0] i, input logic [7:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata[7:0];
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rchk(input logic [9:0] i, input logic [7:0] x);
		apb(1'b0, i, 8'h00);
		chk({8'h00, rd}, {8'h00, x});
	endtask : rchk
	task tick(input int n);
		repeat (n)
		begin
			@(posedge ref_clk);
			frame_tick <= 1'b1;
			@(posedge ref_clk);
			frame_tick <= 1'b0;
		end
		repeat (2) @(posedge ref_clk);
		#1;
	endtask : tick
	task strobe(input bit g);
		@(posedge ref_clk);
		if (g) bus_grant <= 1'b1;
		else bus_request <= 1'b1;
		@(posedge ref_clk);
		bus_grant <= 1'b0;
		bus_request <= 1'b0;
	endtask : strobe
	task fill(input logic [13:0] f, input logic x);
		@(posedge ref_clk);
		best_effort_fill <= f;
		repeat (2) @(posedge ref_clk);
		#1 chk(16'(discard_active), 16'(x));
	endtask : fill
	task t_regs;
		rchk(CSC_IDX_PAGE_CFG, 8'h02);
		rchk(CSC_IDX_GRANT_TMO, 8'hff);
		rchk(CSC_IDX_PEN_HI, 8'hff);
		apb(1'b1, CSC_IDX_PAGE_CFG, 8'h03);
		rchk(CSC_IDX_PAGE_CFG, 8'h02);
		apb(1'b1, CSC_IDX_IF_MODE, 8'hfb);
		rchk(CSC_IDX_IF_MODE, 8'h1b);
		apb(1'b1, 10'h050, 8'h55);
		chk(16'(er), 16'h0001);
		rchk(10'h050, 8'h00);
	endtask : t_regs
	task t_modes;
		for (int w = 0; w < 2; w++)
			for (int c = 0; c < 4; c++)
			begin
				apb(1'b1, CSC_IDX_IF_MODE, 8'(w * 2));
				apb(1'b1, CSC_IDX_SIZE_CONG, 8'(c * 5));
				e = c == 0 ? CSC_LEN_53 : c == 3 ? CSC_LEN_57 : 6'h00;
				e = e + ((c == 0 || c == 3) ? 6'(w) : 6'h00);
				#1 chk(16'(inlet_cell_bytes), 16'(e));
				chk(16'(outlet_cell_bytes), 16'(e));
				chk(16'(wide_interface_select), 16'(w));
			end
		apb(1'b1, CSC_IDX_IF_MODE, 8'h01);
		#1 chk(16'(single_phy_select), 16'h0001);
		chk(poll_enable, 16'hffff);
	endtask : t_modes
	task t_mon;
		apb(1'b1, CSC_IDX_IF_MODE, 8'h10);
		#1 chk(16'(bus_monitor_mode), 16'h0001);
		for (int i = 0; i < 33; i++)
		begin
			@(posedge ref_clk);
			cell_dest_id <= 5'(i);
			cell_multicast <= (i == 32);
			@(negedge ref_clk);
			chk(16'(cell_accept), 16'h0001);
			chk({cell_queue_class, cell_queue_port}, 16'(i % 32));
		end
	endtask : t_mon
	task t_ports;
		apb(1'b1, CSC_IDX_IF_MODE, 8'h00);
		apb(1'b1, CSC_IDX_PEN_LO, 8'h5a);
		apb(1'b1, CSC_IDX_PEN_HI, 8'h00);
		#1 chk(poll_enable, 16'h005a);
		chk(port_enable, 16'h005a);
		chk(16'(cell_accept), 16'h0000);
		for (int p = 0; p < 32; p++)
		begin
			@(posedge ref_clk);
			outlet_port <= 4'(p);
			outlet_multicast <= (p > 15);
			@(negedge ref_clk);
			er = (p < 16) && (((16'h005a >> p) & 16'h0001) == 16'h0000);
			chk(16'(outlet_discard), 16'(er));
		end
	endtask : t_ports
	task t_wd;
		apb(1'b1, CSC_IDX_GRANT_TMO, 8'h03);
		apb(1'b1, CSC_IDX_IRQ_MASK, 8'h01);
		strobe(1'b0);
		tick(2);
		chk(16'(no_grant_alarm), 16'h0000);
		tick(1);
		chk({irq, no_grant_alarm}, 16'h0003);
		apb(1'b1, CSC_IDX_IRQ_MASK, 8'h00);
		#1 chk({irq, no_grant_alarm}, 16'h0001);
		apb(1'b1, CSC_IDX_IRQ_STAT, 8'h01);
		#1 chk({irq, no_grant_alarm}, 16'h0000);
		strobe(1'b0);
		tick(1);
		strobe(1'b1);
		tick(4);
		chk(16'(no_grant_alarm), 16'h0000);
	endtask : t_wd
	task t_misc;
		apb(1'b1, CSC_IDX_FL_LO, 8'h34);
		apb(1'b1, CSC_IDX_FL_HI, 8'h02);
		apb(1'b1, CSC_IDX_IF_MODE, 8'h04);
		#1 chk(16'(free_list_reload), 16'h0001);
		chk(16'(free_list_head_pointer), 16'h0234);
		@(posedge ref_clk);
		#1 chk(16'(free_list_reload), 16'h0000);
		rchk(CSC_IDX_IF_MODE, 8'h00);
		apb(1'b1, CSC_IDX_BE_LIM_LO, 8'h64);
		apb(1'b1, CSC_IDX_BE_LIM_HI, 8'h00);
		apb(1'b1, CSC_IDX_IF_MODE, 8'h08);
		fill(14'd100, 1'b0);
		fill(14'd101, 1'b1);
		fill(14'd50, 1'b1);
		fill(14'd49, 1'b0);
		fill(14'd200, 1'b1);
		apb(1'b1, CSC_IDX_IF_MODE, 8'h00);
		fill(14'd200, 1'b0);
		apb(1'b1, CSC_IDX_SIZE_CONG, 8'h10);
		queue_len <= '{12'd73, 12'd90, 12'd0, 12'd0};
		@(negedge ref_clk);
		chk(16'(congestion_mark), 16'h0001);
		queue_len[0] <= 12'd72;
		@(negedge ref_clk);
		chk(16'(congestion_mark), 16'h0000);
	endtask : t_misc
	task test_done;
		$display("mismatches %0d checks %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			mismatches++;
			test_done;
		end
	end
	initial
	begin
		{ref_clk, rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
		{bus_request, bus_grant, frame_tick, cell_dest_id} = '0;
		{cell_multicast, cell_for_us, best_effort_fill} = '0;
		{outlet_port, outlet_multicast} = '0;
		queue_len = '{default: 12'd0};
		queue_max = '{default: 12'd100};
		repeat (3) @(posedge ref_clk);
		rst_b <= 1'b1;
		t_regs;
		$display("registers done");
		t_modes;
		$display("modes done");
		t_mon;
		$display("monitor done");
		t_ports;
		$display("ports done");
		t_wd;
		$display("watchdog done");
		t_misc;
		$display("reload discard congestion done");
		test_done;
	end
endmodule : cell_switch_config_regs_test

// ==== sim/csc_config_regs_sva.sv ====
// checker of the switch config block port behaviour
`timescale 1ns/1ps
module csc_config_regs_sva
	import csc_pkg::*;
(
	input wire logic        ref_clk,                // clock
	input wire logic        rst_b,                  // reset
	input wire logic        psel,                   // apb select
	input wire logic        penable,                // apb enable
	input wire logic        pwrite,                 // apb direction
	input wire logic [11:0] paddr,                  // apb address
	input wire logic [31:0] pwdata,                 // apb data
	input wire logic        frame_tick,             // frame pulse
	input wire logic        no_grant_alarm,         // alarm
	input wire logic [4:0]  cell_dest_id,           // cell id
	input wire logic        cell_multicast,         // cell mcast
	input wire logic        cell_accept,            // accept
	input wire logic [3:0]  cell_queue_port,        // queue port
	input wire logic        cell_queue_class,       // queue class
	input wire logic        bus_monitor_mode,       // monitor
	input wire logic        free_list_reload,       // reload pulse
	input wire logic        wide_interface_select,  // 16-bit
	input wire logic [5:0]  inlet_cell_bytes,       // inlet size
	input wire logic        single_phy_select,      // level 1
	input wire logic [15:0] port_enable,            // enables
	input wire logic [15:0] poll_enable,            // polled
	input wire logic [3:0]  outlet_port,            // outlet port
	input wire logic        outlet_multicast,       // outlet mcast
	input wire logic        outlet_discard          // drop
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	property p_mon_acc;
		bus_monitor_mode |-> cell_accept;
	endproperty
	a_mon_acc: assert property (p_mon_acc) else $error("refused");
	property p_mon_q;
		bus_monitor_mode && !cell_multicast |->
			{cell_queue_class, cell_queue_port} == cell_dest_id;
	endproperty
	a_mon_q: assert property (p_mon_q) else $error("wrong queue");
	property p_mon_mc;
		bus_monitor_mode && cell_multicast |->
			cell_queue_port == 4'h0 && !cell_queue_class;
	endproperty
	a_mon_mc: assert property (p_mon_mc) else $error("mcast queue");
	property p_reload;
		free_list_reload |-> $past(psel && penable && pwrite &&
			paddr[11:2] == CSC_IDX_IF_MODE && pwdata[CSC_BIT_FL_RELOAD]);
	endproperty
	a_reload: assert property (p_reload) else $error("stray reload");
	property p_alarm_rise;
		$rose(no_grant_alarm) |-> $past(frame_tick, 2);
	endproperty
	a_alarm_rise: assert property (p_alarm_rise) else $error("alarm");
	property p_alarm_hold;
		no_grant_alarm && !(psel && penable && pwrite) |=> no_grant_alarm;
	endproperty
	a_alarm_hold: assert property (p_alarm_hold) else $error("lost");
	property p_bytes;
		inlet_cell_bytes != 6'h00 |->
			inlet_cell_bytes[0] == !wide_interface_select;
	endproperty
	a_bytes: assert property (p_bytes) else $error("cell size");
	property p_poll;
		!single_phy_select |-> poll_enable == port_enable;
	endproperty
	a_poll: assert property (p_poll) else $error("poll set");
	property p_odisc;
		outlet_discard == (!outlet_multicast && !port_enable[outlet_port]);
	endproperty
	a_odisc: assert property (p_odisc) else $error("discard");
endmodule : csc_config_regs_sva

bind csc_config_regs csc_config_regs_sva u_sva
(
	.ref_clk               (ref_clk),
	.rst_b                 (rst_b),
	.psel                  (psel),
	.penable               (penable),
	.pwrite                (pwrite),
	.paddr                 (paddr),
	.pwdata                (pwdata),
	.frame_tick            (frame_tick),
	.no_grant_alarm        (no_grant_alarm),
	.cell_dest_id          (cell_dest_id),
	.cell_multicast        (cell_multicast),
	.cell_accept           (cell_accept),
	.cell_queue_port       (cell_queue_port),
	.cell_queue_class      (cell_queue_class),
	.bus_monitor_mode      (bus_monitor_mode),
	.free_list_reload      (free_list_reload),
	.wide_interface_select (wide_interface_select),
	.inlet_cell_bytes      (inlet_cell_bytes),
	.single_phy_select     (single_phy_select),
	.port_enable           (port_enable),
	.poll_enable           (poll_enable),
	.outlet_port           (outlet_port),
	.outlet_multicast      (outlet_multicast),
	.outlet_discard        (outlet_discard)
);

// ==== verilog/csc_config_regs.sv ====
// cell switch configuration registers with apb slave and queue-side decode
`timescale 1ns/1ps
module csc_config_regs
	import csc_pkg::*;
(
	input  wire logic        ref_clk,           // 25 mhz clock
	input  wire logic        rst_b,             // async reset, active low
	input  wire logic        psel,              // apb select
	input  wire logic        penable,           // apb access phase
	input  wire logic        pwrite,            // apb direction
	input  wire logic [11:0] paddr,             // apb byte address
	input  wire logic [31:0] pwdata,            // apb write data
	output logic             pready,            // apb ready
	output logic [31:0]      prdata,            // apb read data
	output logic             pslverr,           // apb error
	output logic             irq,               // level interrupt
	input  wire logic        bus_request,       // bus access request
	input  wire logic        bus_grant,         // bus grant
	input  wire logic        frame_tick,        // bus frame cycle pulse
	output logic             no_grant_alarm,    // sticky alarm
	input  wire logic [4:0]  cell_dest_id,      // incoming cell destination
	input  wire logic        cell_multicast,    // cell is bcast/mcast
	input  wire logic        cell_for_us,       // id matches own id
	output logic             cell_accept,       // take the cell
	output logic [3:0]       cell_queue_port,   // queue port chosen
	output logic             cell_queue_class,  // 0 or 1 in monitor
	output logic             bus_monitor_mode,  // monitor bit
	input  wire logic [13:0] best_effort_fill,  // summed ubr/gfr fill
	output logic             discard_active,    // ubr/gfr discard mode
	output logic             free_list_reload,  // one-cycle load pulse
	output logic [9:0]       free_list_head_pointer, // new head
	output logic             wide_interface_select,  // 16-bit mode
	output logic             single_phy_select,      // level 1 mode
	input  wire logic [11:0] queue_len [CSC_NUM_CLASS], // per class
	input  wire logic [11:0] queue_max [CSC_NUM_CLASS], // per class
	output logic [3:0]       congestion_mark,   // set efci per class
	output logic [5:0]       inlet_cell_bytes,  // 0 if reserved code
	output logic [5:0]       outlet_cell_bytes, // 0 if reserved code
	output logic [15:0]      port_enable,       // per-port enables
	output logic [15:0]      poll_enable,       // ports to poll
	input  wire logic [3:0]  outlet_port,       // outlet cell port
	input  wire logic        outlet_multicast,  // outlet cell is mcast
	output logic             outlet_discard     // drop this outlet cell
);
	import csc_pkg::*;

	logic [7:0]  page_cfg_r;
	logic [7:0]  grant_tmo_r;
	logic [7:0]  if_mode_r;
	logic [7:0]  size_cong_r;
	logic [7:0]  pen_lo_r;
	logic [7:0]  pen_hi_r;
	logic [7:0]  fl_lo_r;
	logic [7:0]  fl_hi_r;
	logic [7:0]  lim_lo_r;
	logic [7:0]  lim_hi_r;
	logic [7:0]  irq_stat_r;
	logic [7:0]  irq_mask_r;
	logic        discard_r;
	logic        reload_r;
	logic        wd_expired;
	logic [9:0]  idx;
	logic        mapped;
	logic        wr_en;
	logic [7:0]  wdat;
	logic [7:0]  rd_nxt;
	logic [13:0] limit;
	logic [7:0]  ev_nxt;

	// single-cycle access phase: ready always high keeps the slave simple
	assign pready = 1'b1;
	assign idx    = paddr[11:2];
	assign wdat   = pwdata[7:0];
	assign wr_en  = psel && penable && pwrite && mapped;

	always_comb
	begin
		mapped = 1'b1;
		rd_nxt = 8'h00;
		case (idx)
			CSC_IDX_PAGE_CFG:  rd_nxt = page_cfg_r;
			CSC_IDX_GRANT_TMO: rd_nxt = grant_tmo_r;
			CSC_IDX_IF_MODE:   rd_nxt = if_mode_r;
			CSC_IDX_SIZE_CONG: rd_nxt = size_cong_r;
			CSC_IDX_PEN_LO:    rd_nxt = pen_lo_r;
			CSC_IDX_PEN_HI:    rd_nxt = pen_hi_r;
			CSC_IDX_FL_LO:     rd_nxt = fl_lo_r;
			CSC_IDX_FL_HI:     rd_nxt = fl_hi_r;
			CSC_IDX_BE_LIM_LO: rd_nxt = lim_lo_r;
			CSC_IDX_BE_LIM_HI: rd_nxt = lim_hi_r;
			CSC_IDX_ALARM:     rd_nxt = {7'h00, irq_stat_r[CSC_BIT_NOGRANT]};
			CSC_IDX_IRQ_STAT:  rd_nxt = irq_stat_r;
			CSC_IDX_IRQ_MASK:  rd_nxt = irq_mask_r;
			default:           mapped = 1'b0;
		endcase
	end

	// unmapped addresses answer with an error and read zero
	// read data and error are captured in the setup cycle, so the
	// access phase shows them from flops with no wait state
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else if (psel && !penable)
		begin
			prdata  <= mapped ? {24'h000000, rd_nxt} : 32'h00000000;
			pslverr <= !mapped;
		end
		else
		begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end
	end

	// configuration storage, one process per register or per lo/hi register pair
	// reserved bits are dropped on write so they always read zero
	// page bit1 stored as written; software is expected to keep it 1
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			page_cfg_r <= CSC_RST_PAGE_CFG;
		else if (wr_en && idx == CSC_IDX_PAGE_CFG)
			page_cfg_r <= wdat & CSC_MSK_PAGE_CFG;
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			grant_tmo_r <= CSC_RST_GRANT;
		else if (wr_en && idx == CSC_IDX_GRANT_TMO)
			grant_tmo_r <= wdat;
	end

	// reload bit is a strobe and is not stored
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			if_mode_r <= CSC_RST_ZERO;
		else if (wr_en && idx == CSC_IDX_IF_MODE)
			if_mode_r <= wdat & CSC_MSK_IF_MODE
				& ~(8'h01 << CSC_BIT_FL_RELOAD);
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			size_cong_r <= CSC_RST_ZERO;
		else if (wr_en && idx == CSC_IDX_SIZE_CONG)
			size_cong_r <= wdat;
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pen_lo_r <= CSC_RST_PEN;
			pen_hi_r <= CSC_RST_PEN;
		end
		else if (wr_en && idx == CSC_IDX_PEN_LO)
			pen_lo_r <= wdat;
		else if (wr_en && idx == CSC_IDX_PEN_HI)
			pen_hi_r <= wdat;
	end

	// free-list halves are only combined when the reload strobe fires
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			fl_lo_r <= CSC_RST_ZERO;
			fl_hi_r <= CSC_RST_ZERO;
		end
		else if (wr_en && idx == CSC_IDX_FL_LO)
			fl_lo_r <= wdat;
		else if (wr_en && idx == CSC_IDX_FL_HI)
			fl_hi_r <= wdat & CSC_MSK_FL_HI;
	end

	// limit halves feed the discard hysteresis below
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			lim_lo_r <= CSC_RST_ZERO;
			lim_hi_r <= CSC_RST_ZERO;
		end
		else if (wr_en && idx == CSC_IDX_BE_LIM_LO)
			lim_lo_r <= wdat;
		else if (wr_en && idx == CSC_IDX_BE_LIM_HI)
			lim_hi_r <= wdat & CSC_MSK_LIM_HI;
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			irq_mask_r <= CSC_RST_ZERO;
		else if (wr_en && idx == CSC_IDX_IRQ_MASK)
			irq_mask_r <= wdat & CSC_MSK_IRQ;
	end

	// free-list reload strobe
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			reload_r               <= 1'b0;
			free_list_head_pointer <= 10'h000;
		end
		else
		begin
			reload_r <= wr_en && idx == CSC_IDX_IF_MODE
				&& wdat[CSC_BIT_FL_RELOAD];
			if (wr_en && idx == CSC_IDX_IF_MODE && wdat[CSC_BIT_FL_RELOAD])
				free_list_head_pointer <= {fl_hi_r[1:0], fl_lo_r};
		end
	end
	assign free_list_reload = reload_r;

	csc_grant_watchdog u_wd
	(
		.ref_clk     (ref_clk),
		.rst_b       (rst_b),
		.preset      (grant_tmo_r),
		.bus_request (bus_request),
		.bus_grant   (bus_grant),
		.frame_tick  (frame_tick),
		.expired     (wd_expired)
	);

	// sticky events: set wins over write-one-to-clear
	assign ev_nxt = {6'h00, reload_r, wd_expired};
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			irq_stat_r <= CSC_RST_ZERO;
		else
		begin
			if (wr_en && (idx == CSC_IDX_IRQ_STAT || idx == CSC_IDX_ALARM))
				irq_stat_r <= ((irq_stat_r & ~(idx == CSC_IDX_ALARM ?
					(wdat & 8'h01) : wdat)) | ev_nxt) & CSC_MSK_IRQ;
			else
				irq_stat_r <= (irq_stat_r | ev_nxt) & CSC_MSK_IRQ;
		end
	end
	assign no_grant_alarm = irq_stat_r[CSC_BIT_NOGRANT];
	assign irq            = |(irq_stat_r & irq_mask_r);

	// packet discard hysteresis on aggregate best-effort fill
	assign limit = {lim_hi_r[5:0], lim_lo_r};
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			discard_r <= 1'b0;
		else if (!if_mode_r[CSC_BIT_PD_EN])
			discard_r <= 1'b0;
		else if (best_effort_fill > limit)
			discard_r <= 1'b1;
		else if (best_effort_fill < {1'b0, limit[13:1]})
			discard_r <= 1'b0;
	end
	assign discard_active = discard_r && if_mode_r[CSC_BIT_PD_EN];

	// mode outputs
	assign bus_monitor_mode      = if_mode_r[CSC_BIT_MONITOR];
	assign wide_interface_select = if_mode_r[CSC_BIT_WIDE];
	assign single_phy_select     = if_mode_r[CSC_BIT_SINGLE_PHY];

	// incoming bus cell steering
	always_comb
	begin
		cell_accept      = cell_for_us;
		cell_queue_port  = cell_dest_id[3:0];
		cell_queue_class = 1'b0;
		if (bus_monitor_mode)
		begin
			cell_accept = 1'b1;
			if (cell_multicast)
				cell_queue_port = 4'h0;
			else
				cell_queue_class = cell_dest_id[4];
		end
	end

	// congestion marking, index 0 is the highest-priority class
	genvar gc;
	generate
		for (gc = 0; gc < CSC_NUM_CLASS; gc = gc + 1)
		begin : g_cong
			// guard against maxima below the margin wrapping around
			assign congestion_mark[gc] = size_cong_r[4 + gc]
				&& (queue_max[gc] < CSC_CONG_MARGIN
				|| queue_len[gc] >= queue_max[gc] - CSC_CONG_MARGIN);
		end
	endgenerate

	// cell length decode; reserved codes give zero
	function automatic logic [5:0] csc_len(input logic [1:0] code,
		input logic wide);
		csc_len = 6'd0;
		if (code == CSC_SIZE_STD)
			csc_len = wide ? CSC_LEN_54 : CSC_LEN_53;
		else if (code == CSC_SIZE_EXT)
			csc_len = wide ? CSC_LEN_58 : CSC_LEN_57;
	endfunction : csc_len

	assign inlet_cell_bytes  = csc_len(size_cong_r[1:0],
		wide_interface_select);
	assign outlet_cell_bytes = csc_len(size_cong_r[3:2],
		wide_interface_select);

	// port enables
	assign port_enable = {pen_hi_r, pen_lo_r};
	// single-phy mode has nothing to poll per port, so all stay open
	assign poll_enable = single_phy_select ? 16'hffff : port_enable;
	assign outlet_discard = !outlet_multicast
		&& !port_enable[outlet_port];
endmodule : csc_config_regs

// ==== verilog/csc_grant_watchdog.sv ====
// bus-grant watchdog: counts shared-bus frames from a request until grant
`timescale 1ns/1ps
module csc_grant_watchdog
	import csc_pkg::*;
(
	input  wire logic       ref_clk,      // system clock
	input  wire logic       rst_b,        // async reset, active low
	input  wire logic [7:0] preset,       // frames allowed before alarm
	input  wire logic       bus_request,  // pulse: bus access requested
	input  wire logic       bus_grant,    // pulse: grant received
	input  wire logic       frame_tick,   // pulse: one bus frame cycle
	output logic            expired       // pulse: count ran out
);
	csc_wd_state_t state_r;
	logic [7:0]    count_r;

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_r <= CSC_WD_IDLE;
			count_r <= 8'h00;
			expired <= 1'b0;
		end
		else
		begin
			expired <= 1'b0;
			case (state_r)
				CSC_WD_IDLE:
				begin
					if (bus_request && !bus_grant)
					begin
						count_r <= preset;
						state_r <= CSC_WD_RUN;
					end
				end
				CSC_WD_RUN:
				begin
					if (bus_grant)
						state_r <= CSC_WD_IDLE;
					else if (frame_tick)
					begin
						// a zero preset expires on the first frame
						if (count_r <= 8'h01)
						begin
							expired <= 1'b1;
							state_r <= CSC_WD_EXPIRED;
							count_r <= 8'h00;
						end
						else
							count_r <= count_r - 8'h01;
					end
				end
				CSC_WD_EXPIRED:
				begin
					// wait for a grant or a fresh request to re-arm
					if (bus_grant)
						state_r <= CSC_WD_IDLE;
					else if (bus_request)
					begin
						count_r <= preset;
						state_r <= CSC_WD_RUN;
					end
				end
				default: state_r <= CSC_WD_IDLE;
			endcase
		end
	end
endmodule : csc_grant_watchdog

// ==== verilog/csc_pkg.sv ====
// package of register map, field positions and reset values for the switch config block
package csc_pkg;
	// printed offsets are not multiples of four: these are indices, byte address = 4*index
	localparam logic [9:0] CSC_IDX_PAGE_CFG   = 10'h00e;
	localparam logic [9:0] CSC_IDX_GRANT_TMO  = 10'h00f;
	localparam logic [9:0] CSC_IDX_IF_MODE    = 10'h100;
	localparam logic [9:0] CSC_IDX_SIZE_CONG  = 10'h101;
	localparam logic [9:0] CSC_IDX_PEN_LO     = 10'h102;
	localparam logic [9:0] CSC_IDX_PEN_HI     = 10'h103;
	localparam logic [9:0] CSC_IDX_FL_LO      = 10'h10e;
	localparam logic [9:0] CSC_IDX_FL_HI      = 10'h10f;
	localparam logic [9:0] CSC_IDX_BE_LIM_LO  = 10'h10c;
	localparam logic [9:0] CSC_IDX_BE_LIM_HI  = 10'h10d;
	localparam logic [9:0] CSC_IDX_ALARM      = 10'h008;
	localparam logic [9:0] CSC_IDX_IRQ_STAT   = 10'h1f0;
	localparam logic [9:0] CSC_IDX_IRQ_MASK   = 10'h1f1;
	// field positions
	localparam int CSC_BIT_PAGE_ONE   = 1;
	localparam int CSC_BIT_MONITOR    = 4;
	localparam int CSC_BIT_PD_EN      = 3;
	localparam int CSC_BIT_FL_RELOAD  = 2;
	localparam int CSC_BIT_WIDE       = 1;
	localparam int CSC_BIT_SINGLE_PHY = 0;
	localparam int CSC_BIT_NOGRANT    = 0;
	localparam int CSC_BIT_IRQ_FLR    = 1;
	// reset values and write masks
	localparam logic [7:0] CSC_RST_PAGE_CFG = 8'h02;
	localparam logic [7:0] CSC_MSK_PAGE_CFG = 8'hfe;
	localparam logic [7:0] CSC_MSK_IF_MODE  = 8'h1f;
	localparam logic [7:0] CSC_RST_GRANT    = 8'hff;
	localparam logic [7:0] CSC_RST_ZERO     = 8'h00;
	localparam logic [7:0] CSC_RST_PEN      = 8'hff;
	localparam logic [7:0] CSC_MSK_FL_HI    = 8'h03;
	localparam logic [7:0] CSC_MSK_LIM_HI   = 8'h3f;
	localparam logic [7:0] CSC_MSK_IRQ      = 8'h03;
	// queueing constants
	localparam logic [11:0] CSC_CONG_MARGIN = 12'd27;
	localparam logic [1:0]  CSC_SIZE_STD    = 2'b00;
	localparam logic [1:0]  CSC_SIZE_EXT    = 2'b11;
	localparam logic [5:0]  CSC_LEN_53      = 6'd53;
	localparam logic [5:0]  CSC_LEN_54      = 6'd54;
	localparam logic [5:0]  CSC_LEN_57      = 6'd57;
	localparam logic [5:0]  CSC_LEN_58      = 6'd58;
	localparam int          CSC_NUM_CLASS   = 4;
	localparam int          CSC_NUM_PORT    = 16;
	typedef enum logic [1:0]
	{
		CSC_WD_IDLE    = 2'b00,
		CSC_WD_RUN     = 2'b01,
		CSC_WD_EXPIRED = 2'b10
	} csc_wd_state_t;
endpackage : csc_pkg
